/* rtl/lcp_ladder_slave.sv */
// Purpose: Lower slave port of a chained monitor, command level decode
// Assumes: Serial clock period at least eight system clocks
// Notes: Upper port and register file sit outside; this block hands them pulses
`default_nettype none
module lcp_ladder_slave (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Serial pins (clock sensed only)
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Register file side
   input wire logic [15:0] i_rd_data,
   output logic [7:0] o_rd_reg,
   output logic o_wr_valid,
   output lcp_pkg::lcp_wr_s o_wr,
   // Chain state and forwarding
   output logic [4:0] o_own_addr,
   output logic [7:0] o_bcast_addr,
   output logic [4:0] o_chain_len,
   output logic o_fwd_enum,
   output logic [7:0] o_fwd_byte
);
   import lcp_pkg::*;

   logic rst_m, rst_s; // Reset release synchroniser
   logic scl_m, scl_s, scl_d; // Clock pin sync and history
   logic sda_m, sda_s, sda_d; // Data pin sync and history
   logic scl_rise, scl_fall, start_c, stop_c;
   lcp_state_e state;
   lcp_kind_e kind;
   logic [3:0] bit_cnt; // Bits seen in current byte, 8/9 around ack
   logic [6:0] shift; // Received bits
   logic [7:0] rx_byte; // Byte completing at this rise
   logic [2:0] byte_idx; // Bytes of this segment
   logic [2:0] tx_idx; // Bytes sent in read phase
   logic [7:0] tx_shift; // Outgoing byte
   logic [7:0] tx_next; // Byte to load next
   logic ack_me; // Drive ack on this byte
   logic master_ack; // Host acknowledged our byte
   logic [7:0] crc, next_crc;
   logic [7:0] crc_byte; // Checksum at the last byte boundary, ack bit excluded
   logic [4:0] frame_addr; // Address bits of the byte on the line, A0 sits in bit 5
   logic [4:0] frame_next; // Enumeration address handed to the device above
   logic pec_ok; // Checksum matched after PEC byte
   logic [7:0] data_lo, data_hi;
   logic [7:0] cmd;
   logic in_frame;
   logic pec_need, commit;

   // Reset is released through two flops
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge i_clk or negedge rst_s) begin
      if (!rst_s) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else if (i_ce) begin
         scl_m <= i_scl; // R15
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= i_sda;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   // Bus events from synchronised copies
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign rx_byte = {shift, sda_s};
   // Address arrives least significant bit first, so reverse it before use
   assign frame_addr = {rx_byte[1], rx_byte[2], rx_byte[3], rx_byte[4], rx_byte[5]}; // R16
   // Five-bit sum drops the carry, so 0x1F moves on to zero
   assign frame_next = frame_addr + 5'h01; // R4 R18

   // Checksum step for the bit on the line
   lcp_crc8_step u_crc (
      .i_crc(crc),
      .i_bit(sda_s),
      .o_crc(next_crc)
   );

   // Host PEC needed once a length is known, and always for setting it
   assign pec_need = (o_chain_len != LCP_LEN_RST) || (cmd == LCP_REG_CHAIN_LEN); // R9 R10
   // Write word complete: address, command, low, high, optional PEC
   assign commit = stop_c && ((kind == LCP_K_BWRITE) || (kind == LCP_K_SINGLE)) && // R11 R13
                   (pec_need ? (byte_idx == 3'h5 && pec_ok) : (byte_idx == LCP_IDX_PEC)); // R14

   // Outgoing byte chosen by command and position
   always_comb begin
      tx_next = LCP_FILL; // R6
      if (kind == LCP_K_RDCNT) begin
         if (tx_idx < 3'h2) begin
            tx_next = {3'b000, o_own_addr}; // R5
         end
      end else if (kind == LCP_K_RDALL) begin
         if (tx_idx == 3'h0) begin
            tx_next = i_rd_data[7:0]; // R12
         end else if (tx_idx == 3'h1) begin
            tx_next = i_rd_data[15:8];
         end else if (tx_idx == 3'h2) begin
            tx_next = crc; // R12 R2
         end
      end
   end

   // Checksum runs over every data bit of a frame, repeated start included
   always_ff @(posedge i_clk or negedge rst_s) begin
      if (!rst_s) begin
         crc <= LCP_CRC_INIT;
         crc_byte <= LCP_CRC_INIT;
         in_frame <= 1'b0;
      end else if (i_ce) begin
         if (start_c && !in_frame) begin
            crc <= LCP_CRC_INIT; // R19
            crc_byte <= LCP_CRC_INIT;
            in_frame <= 1'b1;
         end else if (start_c) begin
            // The clock rise leading into a repeated start carries no data bit; drop it
            crc <= crc_byte; // R2
         end else if (stop_c) begin
            in_frame <= 1'b0;
         end else if (scl_rise && state != LCP_ST_IGN && state != LCP_ST_IDLE) begin
            if (bit_cnt < LCP_BIT_ACK) begin
               crc <= next_crc; // R2
            end else begin
               crc_byte <= crc; // Byte complete at the ack slot
            end
         end
      end
   end

   // Bit and byte engine
   always_ff @(posedge i_clk or negedge rst_s) begin
      if (!rst_s) begin
         state <= LCP_ST_IDLE;
         kind <= LCP_K_NONE;
         bit_cnt <= 4'h0;
         shift <= 7'h00;
         byte_idx <= 3'h0;
         tx_idx <= 3'h0;
         tx_shift <= LCP_FILL;
         ack_me <= 1'b0;
         master_ack <= 1'b0;
         pec_ok <= 1'b0;
         data_lo <= 8'h00;
         data_hi <= 8'h00;
         cmd <= 8'h00;
         o_sda_oe <= 1'b0;
         o_sda_out <= 1'b0;
         o_own_addr <= LCP_ADDR_RST;
         o_fwd_enum <= 1'b0;
         o_fwd_byte <= 8'h00;
      end else if (i_ce) begin
         o_fwd_enum <= 1'b0;
         o_sda_out <= 1'b0; // Open drain: only ever pulls low
         if (start_c) begin
            // Start or repeated start opens an address byte
            state <= LCP_ST_RX;
            bit_cnt <= 4'h0;
            byte_idx <= 3'h0;
            tx_idx <= 3'h0;
            o_sda_oe <= 1'b0;
         end else if (stop_c) begin
            state <= LCP_ST_IDLE;
            kind <= LCP_K_NONE;
            o_sda_oe <= 1'b0;
         end else if (scl_rise && state != LCP_ST_IDLE && state != LCP_ST_IGN) begin
            if (bit_cnt < LCP_BIT_ACK) begin
               shift <= rx_byte[6:0];
               bit_cnt <= bit_cnt + 4'h1;
            end else begin
               bit_cnt <= LCP_BIT_POST;
               master_ack <= ~sda_s;
            end
            // Byte just completed on the eighth bit
            if (bit_cnt == 4'h7 && state == LCP_ST_RX) begin
               byte_idx <= byte_idx + 3'h1;
               ack_me <= 1'b1;
               if (byte_idx == 3'h0) begin
                  if (rx_byte[7:6] == 2'b11 && !rx_byte[0]) begin
                     kind <= LCP_K_ENUM; // R1 R16
                     o_own_addr <= frame_addr; // R3
                     // Forwarded byte keeps the least-significant-first order
                     o_fwd_byte <= {2'b11, frame_next[0], frame_next[1], frame_next[2], frame_next[3],
                                    frame_next[4], 1'b0}; // R4 R18
                     o_fwd_enum <= 1'b1; // R4
                  end else if (rx_byte[7:6] == 2'b10 && !rx_byte[0]) begin
                     kind <= (frame_addr == o_own_addr) ? LCP_K_SINGLE : LCP_K_NONE; // R13
                  end else if (rx_byte[7:1] == o_bcast_addr[7:1]) begin
                     if (rx_byte[0]) begin
                        // Read after repeated start: address register means count query
                        kind <= (cmd == LCP_REG_DEV_ADDR) ? LCP_K_RDCNT : LCP_K_RDALL; // R1 R5 R12
                     end else begin
                        kind <= LCP_K_BWRITE; // R11
                     end
                  end else begin
                     kind <= LCP_K_NONE;
                     ack_me <= 1'b0; // Not ours: stay off the line
                  end
               end else if (byte_idx == 3'h1) begin
                  cmd <= rx_byte; // R14
               end else if (byte_idx == 3'h2) begin
                  data_lo <= rx_byte;
               end else if (byte_idx == 3'h3) begin
                  data_hi <= rx_byte;
               end else if (byte_idx == LCP_IDX_PEC) begin
                  pec_ok <= (next_crc == 8'h00); // R2 R9
               end else begin
                  ack_me <= 1'b0; // Overlong frame is not acknowledged
               end
            end
         end else if (scl_fall && state != LCP_ST_IDLE && state != LCP_ST_IGN) begin
            if (bit_cnt == LCP_BIT_ACK) begin
               // Ack slot: receiver pulls low, transmitter lets go
               o_sda_oe <= (state == LCP_ST_RX) && ack_me;
            end else if (bit_cnt == LCP_BIT_POST) begin
               bit_cnt <= 4'h0;
               o_sda_oe <= 1'b0;
               if ((state == LCP_ST_RX && (kind == LCP_K_RDALL || kind == LCP_K_RDCNT)) ||
                   (state == LCP_ST_TX && master_ack)) begin
                  state <= LCP_ST_TX;
                  tx_shift <= tx_next;
                  o_sda_oe <= ~tx_next[7];
                  tx_idx <= tx_idx + 3'h1;
               end else if (state == LCP_ST_TX) begin
                  state <= LCP_ST_IGN; // Host ended the read with a nack
               end else if (!ack_me) begin
                  state <= LCP_ST_IGN;
               end
            end else if (state == LCP_ST_TX && bit_cnt != 4'h0) begin
               tx_shift <= {tx_shift[6:0], 1'b1};
               o_sda_oe <= ~tx_shift[6];
            end
         end
      end
   end

   // Completed write words land in local state or go to the register file
   always_ff @(posedge i_clk or negedge rst_s) begin
      if (!rst_s) begin
         o_bcast_addr <= LCP_BCAST_RST; // R17
         o_chain_len <= LCP_LEN_RST;
         o_wr_valid <= 1'b0;
         o_wr <= '0;
         o_rd_reg <= 8'h00;
      end else if (i_ce) begin
         o_wr_valid <= 1'b0;
         o_rd_reg <= cmd; // R12
         if (commit) begin
            if (cmd == LCP_REG_BCAST) begin
               o_bcast_addr <= {data_lo[7:1], 1'b0}; // R17
            end else if (cmd == LCP_REG_CHAIN_LEN) begin
               o_chain_len <= data_lo[4:0]; // R9
            end else begin
               o_wr_valid <= 1'b1; // R11 R13
               o_wr <= '{reg_code: cmd, data: {data_hi, data_lo}}; // R14
            end
         end
      end
   end
endmodule // lcp_ladder_slave
`default_nettype wire

/* rtl/lcp_pkg.sv */
// Purpose: Shared constants and types for the ladder command protocol slave port
// Assumes: 40 MHz system clock, serial clock well below a quarter of it
// Notes: Overview of operation follows
// Overview of operation
// R1: Two frame layouts: read-all, write-word others
// R2: Packet error byte is SMBus CRC-8
// R3: Enumeration takes carried address, no PEC
// R4: Forward enumeration with address plus one
// R5: Count query returns two bytes, address
// R6: Count query response ends with 0xFF
// R7: Host enumerates after power cycle
// R8: Host queries count after enumeration
// R9: Stored chain length decides PEC use
// R10: Host sends chain length with PEC
// R11: Broadcast write reaches every device, PEC
// R12: Read-all returns selected register plus PEC
// R13: Single write updates addressed device only
// R14: Write word: addr, cmd, low, high
// R15: Slave port only senses serial clock
// R16: Enumeration byte: 11, five bits LSB-first, 0
// R17: Broadcast address programmable, resets 0x40
// R18: Forwarded address above 0x1F wraps zero
// R19: CRC poly x8+x2+x+1, init zero, MSB-first
`default_nettype none
package lcp_pkg;
   localparam logic [7:0] LCP_BCAST_RST = 8'h40;    // Broadcast address after reset
   localparam logic [7:0] LCP_REG_DEV_ADDR = 8'h01; // Device address register
   localparam logic [7:0] LCP_REG_CHAIN_LEN = 8'h0E; // Chain length command code
   localparam logic [7:0] LCP_REG_BCAST = 8'h0F;    // Broadcast address register
   localparam logic [7:0] LCP_CRC_POLY = 8'h07;     // x^8+x^2+x+1
   localparam logic [7:0] LCP_CRC_INIT = 8'h00;     // Checksum start value
   localparam logic [7:0] LCP_FILL = 8'hFF;         // End-of-response filler
   localparam logic [4:0] LCP_ADDR_RST = 5'h00;     // Device address after reset
   localparam logic [4:0] LCP_LEN_RST = 5'h00;      // Zero means no chain length yet
   localparam logic [3:0] LCP_BIT_ACK = 4'h8;       // Bit count at the ack slot
   localparam logic [3:0] LCP_BIT_POST = 4'h9;      // Bit count after the ack bit
   localparam logic [2:0] LCP_IDX_PEC = 3'h4;       // Byte index of the host PEC

   // Engine states
   typedef enum logic [3:0] {
      LCP_ST_IDLE = 4'b0001,
      LCP_ST_RX = 4'b0010,
      LCP_ST_TX = 4'b0100,
      LCP_ST_IGN = 4'b1000
   } lcp_state_e;

   // Frame kinds
   typedef enum logic [5:0] {
      LCP_K_NONE = 6'b000001,
      LCP_K_ENUM = 6'b000010,
      LCP_K_SINGLE = 6'b000100,
      LCP_K_BWRITE = 6'b001000,
      LCP_K_RDALL = 6'b010000,
      LCP_K_RDCNT = 6'b100000
   } lcp_kind_e;

   // Register write handed to the device register file
   typedef struct packed {
      logic [7:0] reg_code;
      logic [15:0] data;
   } lcp_wr_s;
endpackage
`default_nettype wire

/* rtl/lcp_crc8_step.sv */
// Purpose: One bit step of the packet error checksum
// Assumes: Bits arrive most significant first
// Notes: Pure combinational, instantiated in the port engine
`default_nettype none
module lcp_crc8_step (
   // Checksum in and out
   input wire logic [7:0] i_crc,
   input wire logic i_bit,
   output logic [7:0] o_crc
);
   import lcp_pkg::*;
   logic fb; // Feedback bit
   // Shift left, fold in polynomial when the top bit differs from data
   always_comb begin
      fb = i_crc[7] ^ i_bit;
      o_crc = {i_crc[6:0], 1'b0} ^ (fb ? LCP_CRC_POLY : 8'h00); // R19 R2
   end
endmodule // lcp_crc8_step
`default_nettype wire

/* verification/lcp_ladder_slave_sva.sv */
// Purpose: Port checks for the ladder slave
// Assumes: Serial clock period of eight system clocks or more
// Notes: Bound into every slave instance
`default_nettype none
module lcp_ladder_slave_sva (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   // Outputs under check
   input wire logic o_wr_valid,
   input wire lcp_pkg::lcp_wr_s o_wr,
   input wire logic [4:0] o_own_addr,
   input wire logic [7:0] o_bcast_addr,
   input wire logic o_fwd_enum,
   input wire logic [7:0] o_fwd_byte
);
   import lcp_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   AST_WR_PULSE: assert property (o_wr_valid |=> !o_wr_valid)
      else $error("write strobe longer than one cycle");
   AST_WR_HOLD: assert property (!o_wr_valid |-> $stable(o_wr))
      else $error("write word moved without a commit");
   AST_WR_STOP: assert property (o_wr_valid |-> i_scl && i_sda)
      else $error("commit before the line went idle");
   AST_FWD_PULSE: assert property (o_fwd_enum |=> !o_fwd_enum)
      else $error("forward strobe longer than one cycle");
   AST_FWD_FORM: assert property (o_fwd_enum |-> o_fwd_byte[7:6] == 2'h3 && !o_fwd_byte[0])
      else $error("forwarded enumeration byte badly framed");
   AST_FWD_INC: assert property (o_fwd_enum |=>
      {o_fwd_byte[1], o_fwd_byte[2], o_fwd_byte[3], o_fwd_byte[4], o_fwd_byte[5]} == o_own_addr + 5'h01)
      else $error("forwarded address is not own address plus one");
   AST_OPEN_DRAIN: assert property (o_sda_out == 1'b0)
      else $error("data pin driven high");
   AST_SDA_LOW_CLK: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data pull changed while clock high");
   AST_BCAST_EVEN: assert property (o_bcast_addr[0] == 1'b0)
      else $error("broadcast address uses the direction bit");
endmodule // lcp_ladder_slave_sva
bind lcp_ladder_slave lcp_ladder_slave_sva chk_u (.*);
`default_nettype wire

/* verification/lcp_host_model.sv */
// Purpose: Host two-wire master for the ladder slave port
// Assumes: Quarter bit of two clocks, so a 200 ns bit
// Notes: Clock parked high between frames; slow adds wait per quarter
`default_nettype none
module lcp_host_model (
   // Timing reference and resolved data line
   input wire logic i_clk,
   input wire logic i_sda,
   // Serial clock and data pull-down
   output logic o_scl,
   output logic o_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   int slow = 0; // Extra clocks per quarter bit
   initial begin
      o_scl = 1'b1;
      o_pull = 1'b0;
   end
   // Quarter bit, driven just after an edge
   task automatic q();
      repeat (2 + slow) @(posedge i_clk);
      #1;
   endtask
   // One bit slot; data only moves while the clock is low
   task automatic clk_bit(input logic drv, output logic smp);
      o_pull = drv;
      q();
      o_scl = 1'b1;
      q();
      smp = i_sda;
      q();
      o_scl = 1'b0;
      q();
   endtask
   // Start or repeated start: data falls under a high clock
   task automatic start();
      o_pull = 1'b0;
      q();
      o_scl = 1'b1;
      q();
      o_pull = 1'b1;
      q();
      o_scl = 1'b0;
      q();
   endtask
   // Stop: data rises under a high clock
   task automatic stop();
      o_pull = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_pull = 1'b0;
      q();
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic ack_drv, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) clk_bit(!tx[i], rx[i]);
      clk_bit(ack_drv, ack);
   endtask
endmodule // lcp_host_model
`default_nettype wire

/* verification/ladder_command_protocol_bench.sv */
// Purpose: Self-checking bench for the ladder slave port
// Assumes: One device in the chain, host model as far side
// Notes: Write frames from a table, reads and refusals by hand
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module ladder_command_protocol_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lcp_pkg::*;
   // Address, command, data, PEC mode (0 none, 1 good, 2 bad), commit expected
   typedef struct packed {
      logic [7:0] a, c, lo, hi;
      logic [1:0] pm;
      logic cm;
   } lcp_row_s;
   localparam lcp_row_s ROWS [8] = '{
      '{8'hA0, 8'h12, 8'h34, 8'h56, 2'h0, 1'b1},
      '{8'h90, 8'h12, 8'h34, 8'h56, 2'h0, 1'b0},
      '{8'h40, 8'h0E, 8'h03, 8'h00, 2'h1, 1'b0},
      '{8'h40, 8'h30, 8'h78, 8'h9A, 2'h1, 1'b1},
      '{8'h40, 8'h31, 8'h11, 8'h22, 2'h2, 1'b0},
      '{8'h40, 8'h33, 8'h11, 8'h22, 2'h0, 1'b0},
      '{8'hA0, 8'h21, 8'hBC, 8'hDE, 2'h1, 1'b1},
      '{8'h40, 8'h0F, 8'h62, 8'h00, 2'h1, 1'b0}
   };
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] rd_data = 16'hA55A;
   logic scl, pull, oe, sda_out, wr_valid, fwd, ack;
   logic [7:0] rd_reg, bcast, fwd_byte, crc, b, pec, rx;
   logic [4:0] own, clen;
   lcp_wr_s wr;
   int n_fail = 0;
   int checks_done = 0;
   int n_commit = 0;
   int n_fwd = 0;
   int cyc = 0;
   int base;
   wire sda = !(oe | pull); // Pulled up, low when either side pulls
   lcp_ladder_slave dut_u (.i_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(oe), .i_rd_data(rd_data), .o_rd_reg(rd_reg), .o_wr_valid(wr_valid),
      .o_wr(wr), .o_own_addr(own), .o_bcast_addr(bcast), .o_chain_len(clen), .o_fwd_enum(fwd),
      .o_fwd_byte(fwd_byte));
   lcp_host_model host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
   always #12.5 clk = ~clk;
   // Commit counter and run ceiling
   always @(posedge clk) begin
      if (wr_valid === 1'b1) n_commit++;
      if (fwd === 1'b1) n_fwd++;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // Checksum, polynomial 0x07, MSB first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] v);
      for (int i = 7; i >= 0; i--) c = (c[7] ^ v[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic wb(input logic [7:0] v);
      crc = crc8(crc, v);
      host_u.byte_io(v, 1'b0, rx, ack);
   endtask
   task automatic rb(input logic nk);
      host_u.byte_io(8'hFF, !nk, b, ack);
      crc = crc8(crc, b);
   endtask
   task automatic frame(input lcp_row_s r);
      crc = 8'h00;
      host_u.start();
      wb(r.a);
      wb(r.c);
      wb(r.lo);
      wb(r.hi);
      if (r.pm != 2'h0) wb(crc ^ {7'h00, r.pm[1]}); // Mode 2 corrupts the checksum
      host_u.stop();
      repeat (8) @(posedge clk);
   endtask
   task automatic enum_chk(input logic [7:0] v, input logic [4:0] ea, input logic [7:0] ef);
      int f0;
      f0 = n_fwd;
      frame('{v, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0});
      `CHK("fwd_pulse", 1, n_fwd - f0)
      `CHK("own", ea, own)
      `CHK("fwd", ef, fwd_byte)
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (5) @(posedge clk);
      `CHK("bcast", 8'h40, bcast)
      `CHK("own0", 5'h00, own)
      `CHK("len0", 5'h00, clen)
      `CHK("sda_out", 1'b0, sda_out)
      enum_chk(8'hFE, 5'h1F, 8'hC0);
      enum_chk(8'hE8, 5'h05, 8'hD8);
      enum_chk(8'hE0, 5'h01, 8'hD0);
      crc = 8'h00; // Count query after enumeration, slow host
      host_u.slow = 1;
      host_u.start();
      wb(8'h40);
      wb(8'h01);
      host_u.start();
      wb(8'h41);
      rb(1'b0);
      `CHK("cnt_a", 8'h01, b)
      rb(1'b0);
      `CHK("cnt_b", 8'h01, b)
      rb(1'b1);
      `CHK("cnt_end", 8'hFF, b)
      host_u.stop();
      host_u.slow = 0;
      crc = 8'h00; // Read-all of register 0x44
      host_u.start();
      wb(8'h40);
      wb(8'h44);
      host_u.start();
      wb(8'h41);
      rb(1'b0);
      `CHK("rd_lo", 8'h5A, b)
      rb(1'b0);
      `CHK("rd_hi", 8'hA5, b)
      pec = crc;
      rb(1'b0);
      `CHK("rd_pec", pec, b)
      rb(1'b1);
      `CHK("rd_end", 8'hFF, b)
      host_u.stop();
      `CHK("rd_reg", 8'h44, rd_reg)
      for (int i = 0; i < 8; i++) begin
         base = n_commit;
         frame(ROWS[i]);
         `CHK("commit", int'(ROWS[i].cm), n_commit - base)
         if (ROWS[i].cm) `CHK("word", {ROWS[i].c, ROWS[i].hi, ROWS[i].lo}, wr)
      end
      `CHK("len", 5'h03, clen)
      `CHK("bcast2", 8'h62, bcast)
      frame('{8'h40, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0});
      `CHK("old_bcast_nack", 1'b1, ack)
      report_and_stop();
   end
endmodule // ladder_command_protocol_bench
`default_nettype wire
